// >>> pcci_defines.svh
// constants of the printer control code interpreter
`ifndef PCCI_DEFINES_SVH
`define PCCI_DEFINES_SVH
`define PCCI_NUL 8'h00
`define PCCI_LF 8'h0a
`define PCCI_VT 8'h0b
`define PCCI_FF 8'h0c
`define PCCI_CR 8'h0d
`define PCCI_SO 8'h0e
`define PCCI_SI 8'h0f
`define PCCI_DC1 8'h11
`define PCCI_DC3 8'h13
`define PCCI_DC4 8'h14
`define PCCI_CAN 8'h18
`define PCCI_ESC 8'h1b
`define PCCI_GS 8'h1d
`define PCCI_RS 8'h1e
`define PCCI_US 8'h1f
`define PCCI_SP 8'h20
`define PCCI_DEL 8'h7f
`define PCCI_DIG0 8'h30
`define PCCI_DIG9 8'h39
`define PCCI_CH1 8'h31
`define PCCI_CH12 8'h3c
`define PCCI_QMARK 8'h3f
`define PCCI_ESC_F 8'h46
`define PCCI_ESC_5 8'h35
`define PCCI_ESC_6 8'h36
`define PCCI_ESC_8 8'h38
`define PCCI_ESC_A 8'h41
`define PCCI_ESC_B 8'h42
`define PCCI_FMT_SLOTS 12
`define PCCI_FMT_LINES 128
`define PCCI_LONG_10 8'd80
`define PCCI_LONG_16 8'd132
`define PCCI_SHORT_10 8'd64
`define PCCI_SHORT_16 8'd106
`define PCCI_PE_LINES 3'd4
`define PCCI_TEN 7'd10
`endif

// >>> pcci_pkg.sv
// types of the printer control code interpreter
package pcci_pkg;
   typedef enum logic [2:0] {
      PCCI_IDLE = 3'b000,
      PCCI_ESC_WAIT = 3'b001,
      PCCI_DIG1 = 3'b011,
      PCCI_DIG2 = 3'b010,
      PCCI_VT_CH = 3'b110,
      PCCI_LOAD = 3'b111
   } pcci_state_t;

   typedef enum logic [1:0] {
      PCCI_OP_NONE = 2'b00,
      PCCI_OP_SKIP = 2'b01,
      PCCI_OP_PLEN = 2'b10
   } pcci_op_t;

   // one entry towards the print engine
   typedef struct packed {
      logic [7:0] ch;
      logic wide;
      logic shift_out;
      logic is_eol;
      logic discard;
      logic [7:0] feed;
   } pcci_item_t;

   // print settings visible to the engine
   typedef struct packed {
      logic pitch_16;
      logic lpi_8;
      logic short_line;
      logic selected;
      logic paper_end;
      logic [6:0] page_len;
      logic [6:0] page_line;
   } pcci_cfg_t;
endpackage

// >>> pcci_top.sv
// printer control code interpreter: byte stream to print items and settings
`timescale 1ns/1ps
`default_nettype none
`include "pcci_defines.svh"
module pcci_top
   import pcci_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // byte stream from host
   input wire logic [7:0] rx_data,
   input wire logic rx_valid,
   output logic rx_ready,
   // panel and switches
   input wire logic interface_init_input,
   input wire logic sel_button,
   input wire logic page_start_button,
   input wire logic [6:0] rotary_len,
   input wire logic del_print_sw,
   input wire logic paper_out,
   // print items to engine
   output pcci_item_t item_data,
   output logic item_valid,
   input wire logic item_ready,
   // settings and status
   output pcci_cfg_t cfg,
   output logic descender_en,
   output logic paper_end_n
);

   typedef struct packed {
      pcci_state_t st;
      pcci_op_t op;
      logic [3:0] tens;
      logic [`PCCI_FMT_LINES-1:0][3:0] fmt;
      logic [6:0] load_pos;
      logic loaded;
      logic pitch_16;
      logic pitch_pend_16;
      logic lpi_8;
      logic lpi_pend_8;
      logic short_line;
      logic short_pend;
      logic wide;
      logic shift_out;
      logic selected;
      logic desel_pend;
      logic [7:0] col;
      logic in_line;
      logic rot_mode;
      logic [6:0] plen_sel;
      logic [6:0] page_len;
      logic [6:0] page_line;
      logic pout_seen;
      logic [2:0] pe_cnt;
      logic paper_end;
      pcci_item_t b0;
      pcci_item_t b1;
      logic v0;
      logic v1;
   } pcci_regs_t;

   pcci_regs_t s_r;
   pcci_regs_t s_nxt;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // channel code to channel number, zero if invalid
   function automatic logic [3:0] chan_of(input logic [7:0] c);
      if (c >= `PCCI_CH1 && c <= `PCCI_CH12)
         chan_of = c[3:0];
      else
         chan_of = 4'h0;
   endfunction

   function automatic logic is_digit(input logic [7:0] c);
      is_digit = (c >= `PCCI_DIG0) && (c <= `PCCI_DIG9);
   endfunction

   function automatic logic [7:0] line_max(input logic p16, input logic sh, input logic w);
      logic [7:0] m;
      m = sh ? (p16 ? `PCCI_SHORT_16 : `PCCI_SHORT_10) : (p16 ? `PCCI_LONG_16 : `PCCI_LONG_10);
      line_max = w ? (m >> 1) : m;
   endfunction

   // lines to next tab of channel, zero when none stored
   function automatic logic [7:0] tab_dist(input pcci_regs_t r, input logic [3:0] ch);
      logic [7:0] d;
      logic found;
      logic [6:0] idx;
      d = 8'h00;
      found = 1'b0;
      for (int i = 1; i <= `PCCI_FMT_LINES; i++)
      begin
         idx = 7'((32'(r.page_line) + i) % `PCCI_FMT_LINES);
         if (!found && 7'(i) <= r.load_pos && r.fmt[idx] == ch)
         begin
            found = 1'b1;
            d = 8'(i);
         end
      end
      tab_dist = d;
   endfunction

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   logic take;
   logic [3:0] ch;
   logic [7:0] dval;
   logic push;
   pcci_item_t it;
   logic [7:0] lmax;
   logic [6:0] plen_eff;

   always_comb
   begin
      s_nxt = s_r;
      push = 1'b0;
      it = '0;
      ch = chan_of(rx_data);
      dval = 8'({4'h0, s_r.tens} * 8'd10 + 8'(rx_data[3:0]));
      take = rx_valid && rx_ready;
      lmax = line_max(s_r.pitch_16, s_r.short_line, s_r.wide);
      plen_eff = s_r.page_len;
      it.wide = s_r.wide;
      it.shift_out = s_r.shift_out;

      // button toggles select, but selects only without paper end; deselect waits on line
      if (sel_button)
      begin
         if (!s_r.selected)
            s_nxt.selected = !s_r.paper_end;
         else if (s_r.in_line)
            s_nxt.desel_pend = 1'b1;
         else
            s_nxt.selected = 1'b0;
      end
      if (page_start_button)
      begin
         s_nxt.page_line = 7'h00;
         s_nxt.page_len = s_r.plen_sel;
      end
      if (s_r.rot_mode)
         s_nxt.plen_sel = rotary_len;
      // count printed lines after paper out
      if (paper_out)
         s_nxt.pout_seen = 1'b1;

      if (take && !s_r.selected)
      begin
         s_nxt.st = PCCI_IDLE;
         if (rx_data == `PCCI_DC1)
            s_nxt.selected = 1'b1;
      end
      else if (take)
      begin
         unique case (s_r.st)
            PCCI_IDLE:
            begin
               if (rx_data == `PCCI_ESC)
                  s_nxt.st = PCCI_ESC_WAIT;
               else if (rx_data == `PCCI_VT)
                  s_nxt.st = PCCI_VT_CH;
               else if (rx_data == `PCCI_DC4)
               begin
                  s_nxt.st = PCCI_LOAD;
                  s_nxt.fmt = '0;
                  s_nxt.load_pos = 7'h00;
               end
               else if (rx_data == `PCCI_DC3)
               begin
                  if (s_r.in_line)
                     s_nxt.desel_pend = 1'b1;
                  else
                     s_nxt.selected = 1'b0;
               end
               // pitch pends to line end; ends wide
               else if (rx_data == `PCCI_RS || rx_data == `PCCI_GS)
               begin
                  s_nxt.pitch_pend_16 = (rx_data == `PCCI_GS);
                  s_nxt.wide = 1'b0;
               end
               else if (rx_data == `PCCI_US)
                  s_nxt.wide = 1'b1;
               else if (rx_data == `PCCI_SO)
                  s_nxt.shift_out = 1'b1;
               else if (rx_data == `PCCI_SI)
                  s_nxt.shift_out = 1'b0;
               else if (rx_data == `PCCI_CAN)
               begin
                  push = 1'b1;
                  it.discard = 1'b1;
                  s_nxt.wide = 1'b0;
                  s_nxt.shift_out = 1'b0;
                  s_nxt.col = 8'h00;
                  s_nxt.in_line = 1'b0;
               end
               else if (rx_data == `PCCI_FF)
               begin
                  push = 1'b1;
                  it.is_eol = 1'b1;
                  it.feed = 8'(plen_eff - s_r.page_line);
               end
               else if (rx_data == `PCCI_LF)
               begin
                  push = 1'b1;
                  it.is_eol = 1'b1;
                  it.feed = 8'h01;
               end
               else if (rx_data == `PCCI_CR)
               begin
                  push = s_r.in_line;
                  it.is_eol = 1'b1;
               end
               // DEL dropped unless switch says print
               else if (rx_data >= `PCCI_SP && (rx_data != `PCCI_DEL || del_print_sw))
               begin
                  push = 1'b1;
                  it.ch = rx_data;
                  s_nxt.in_line = 1'b1;
                  if (s_r.wide && s_r.col + 8'h01 >= lmax)
                     it.wide = 1'b0;
                  s_nxt.col = s_r.col + 8'h01;
               end
            end
            PCCI_ESC_WAIT:
            begin
               s_nxt.st = PCCI_IDLE;
               if (rx_data == `PCCI_VT)
               begin
                  s_nxt.st = PCCI_DIG1;
                  s_nxt.op = PCCI_OP_SKIP;
               end
               else if (rx_data == `PCCI_ESC_F)
               begin
                  s_nxt.st = PCCI_DIG1;
                  s_nxt.op = PCCI_OP_PLEN;
               end
               else if (rx_data == `PCCI_ESC_5)
               begin
                  s_nxt.page_line = 7'h00;
                  s_nxt.page_len = s_r.plen_sel;
               end
               else if (rx_data == `PCCI_ESC_6 || rx_data == `PCCI_ESC_8)
                  s_nxt.lpi_pend_8 = (rx_data == `PCCI_ESC_8);
               else if (rx_data == `PCCI_ESC_A || rx_data == `PCCI_ESC_B)
                  s_nxt.short_pend = (rx_data == `PCCI_ESC_B);
            end
            PCCI_DIG1:
            begin
               s_nxt.tens = rx_data[3:0];
               s_nxt.st = is_digit(rx_data) ? PCCI_DIG2 : PCCI_IDLE;
            end
            PCCI_DIG2:
            begin
               s_nxt.st = PCCI_IDLE;
               if (is_digit(rx_data))
               begin
                  if (s_r.op == PCCI_OP_SKIP)
                  begin
                     push = 1'b1;
                     it.is_eol = 1'b1;
                     it.feed = dval;
                  end
                  // set length, 00 back to rotary
                  else
                  begin
                     s_nxt.rot_mode = (dval == 8'h00);
                     s_nxt.plen_sel = (dval == 8'h00) ? rotary_len : 7'(dval);
                  end
               end
            end
            PCCI_VT_CH:
            begin
               s_nxt.st = PCCI_IDLE;
               // drop unloaded, bad or unset channel
               if (s_r.loaded && ch != 4'h0 && tab_dist(s_r, ch) != 8'h00)
               begin
                  push = 1'b1;
                  it.is_eol = 1'b1;
                  it.feed = tab_dist(s_r, ch);
               end
            end
            PCCI_LOAD:
            begin
               if (rx_data == `PCCI_QMARK)
               begin
                  s_nxt.st = PCCI_IDLE;
                  s_nxt.loaded = 1'b1;
               end
               else if (rx_data == `PCCI_SP)
                  s_nxt.load_pos = s_r.load_pos + 7'h01;
               else if (ch != 4'h0)
                  s_nxt.fmt[s_r.load_pos] = ch;
            end
            default:
               s_nxt.st = PCCI_IDLE;
         endcase
      end

      // line boundary: pending settings apply, line count moves
      if (push && it.is_eol)
      begin
         s_nxt.col = 8'h00;
         s_nxt.in_line = 1'b0;
         s_nxt.pitch_16 = s_nxt.pitch_pend_16;
         s_nxt.short_line = s_nxt.short_pend;
         s_nxt.lpi_8 = s_nxt.lpi_pend_8;
         if (s_nxt.desel_pend)
         begin
            s_nxt.selected = 1'b0;
            s_nxt.desel_pend = 1'b0;
         end
         // page wraps; new count only from next page
         if (32'(s_r.page_line) + 32'(it.feed) >= 32'(plen_eff) && plen_eff != 7'h00)
         begin
            s_nxt.page_line = 7'((32'(s_r.page_line) + 32'(it.feed)) % 32'(plen_eff));
            s_nxt.page_len = s_r.plen_sel;
         end
         else
            s_nxt.page_line = 7'(8'(s_r.page_line) + it.feed);
         // stop after a few lines past paper out
         if (s_r.pout_seen)
         begin
            s_nxt.pe_cnt = s_r.pe_cnt + 3'h1;
            if (s_r.pe_cnt + 3'h1 >= `PCCI_PE_LINES)
            begin
               s_nxt.paper_end = 1'b1;
               s_nxt.selected = 1'b0;
            end
         end
      end

      it.feed = push ? it.feed : 8'h00;
      // two-entry buffer towards engine
      if (item_ready && s_r.v0)
      begin
         s_nxt.b0 = s_r.b1;
         s_nxt.v0 = s_r.v1;
         s_nxt.v1 = 1'b0;
      end
      if (push)
      begin
         if (!s_nxt.v0)
         begin
            s_nxt.b0 = it;
            s_nxt.v0 = 1'b1;
         end
         else
         begin
            s_nxt.b1 = it;
            s_nxt.v1 = 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      // reset restores defaults; init input too, but keeps the format and selects only without paper out
      if (rst || interface_init_input)
      begin
         s_r <= '0;
         s_r.st <= PCCI_IDLE;
         s_r.op <= PCCI_OP_NONE;
         s_r.selected <= 1'b1;
         s_r.rot_mode <= 1'b1;
         s_r.plen_sel <= rotary_len;
         s_r.page_len <= rotary_len;
         if (rst)
            s_r.loaded <= 1'b0;
         else
         begin
            s_r.fmt <= s_r.fmt;
            s_r.loaded <= s_r.loaded;
            s_r.load_pos <= s_r.load_pos;
            s_r.selected <= !paper_out;
         end
      end
      else
         s_r <= s_nxt;
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         rx_ready <= 1'b0;
         item_valid <= 1'b0;
         item_data <= '0;
         cfg <= '0;
         descender_en <= 1'b0;
         paper_end_n <= 1'b1;
      end
      else
      begin
         // stall input while buffer may overflow or halted, and on every cycle after one with rx_ready high
         rx_ready <= !s_nxt.v1 && !s_nxt.paper_end && !rx_ready;
         item_valid <= s_nxt.v0;
         item_data <= s_nxt.b0;
         cfg <= {s_nxt.pitch_16, s_nxt.lpi_8, s_nxt.short_line, s_nxt.selected,
                 s_nxt.paper_end, s_nxt.page_len, s_nxt.page_line};
         descender_en <= !s_nxt.lpi_8;
         paper_end_n <= !s_nxt.paper_end;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   chk_del_drop: assert property (@(posedge clk) disable iff (rst)
      (rx_valid && rx_ready && s_r.st == PCCI_IDLE && s_r.selected
       && rx_data == `PCCI_DEL && !del_print_sw) |=> $stable(s_r.col))
      else $error("DEL not dropped");
   chk_desel_only: assert property (@(posedge clk) disable iff (rst || interface_init_input)
      (rx_valid && rx_ready && !s_r.selected && rx_data == `PCCI_DC1 && !sel_button)
      |=> s_r.selected)
      else $error("DC1 did not select");
   chk_wide_on: assert property (@(posedge clk) disable iff (rst || interface_init_input)
      (rx_valid && rx_ready && s_r.st == PCCI_IDLE && s_r.selected && rx_data == `PCCI_US)
      |=> s_r.wide)
      else $error("US did not widen");
   chk_can_clear: assert property (@(posedge clk) disable iff (rst || interface_init_input)
      (rx_valid && rx_ready && s_r.st == PCCI_IDLE && s_r.selected && rx_data == `PCCI_CAN)
      |=> !s_r.wide && !s_r.shift_out && s_r.col == 8'h00)
      else $error("CAN did not clear");
   chk_pitch_hold: assert property (@(posedge clk) disable iff (rst || interface_init_input)
      (s_r.in_line && $past(s_r.in_line)) |-> $stable(s_r.pitch_16))
      else $error("pitch moved mid line");
   chk_lpi_desc: assert property (@(posedge clk) disable iff (rst)
      s_r.lpi_8 |-> !descender_en)
      else $error("descender at 8 lpi");
   chk_halt_stall: assert property (@(posedge clk) disable iff (rst || interface_init_input)
      s_r.paper_end |=> !rx_ready)
      else $error("accepts after paper end");
   chk_reset_cfg: assert property (@(posedge clk)
      rst |=> (s_r.selected && !s_r.pitch_16 && !s_r.lpi_8 && !s_r.short_line))
      else $error("reset state wrong");

endmodule
`default_nettype wire

// >>> pcci_host_model.sv
// host model: offers bytes to the interpreter one at a time
`timescale 1ns/1ps
`default_nettype none
module pcci_host_model
(
   // clock
   input wire logic clk,
   // byte stream to device
   output logic [7:0] rx_data,
   output logic rx_valid,
   input wire logic rx_ready
);
   initial
   begin
      rx_data = 8'h00;
      rx_valid = 1'b0;
   end

   // -----------------------------
   // byte transfer
   // -----------------------------
   // host holds each code until taken or 200 cycles pass, in order
   task automatic send(input logic [7:0] b, output logic taken);
      int n;
      n = 0;
      @(negedge clk);
      rx_data = b;
      rx_valid = 1'b1;
      @(posedge clk);
      while (rx_ready !== 1'b1 && n < 200)
      begin
         n++;
         @(posedge clk);
      end
      taken = (rx_ready === 1'b1);
      @(negedge clk);
      rx_valid = 1'b0;
      // released line shows no stale byte
      rx_data = ~b;
   endtask
endmodule
`default_nettype wire

// >>> test_printer_control_code_interpreter.sv
// testbench of the printer control code interpreter
`timescale 1ns/1ps
`default_nettype none
`include "pcci_defines.svh"
module test_printer_control_code_interpreter;
   import pcci_pkg::*;
   logic clk = 1'b0, rst = 1'b1, rx_valid, rx_ready, init_in = 1'b0, sel_btn = 1'b0;
   logic pst_btn = 1'b0, del_sw = 1'b0, pout = 1'b0, item_valid, item_ready = 1'b1;
   logic descender_en, paper_end_n;
   logic [7:0] rx_data;
   logic [6:0] rot = 7'h42;
   pcci_item_t item_data;
   pcci_cfg_t cfg;
   pcci_item_t items[$];
   int fail_count = 0, compares = 0;

   always #2 clk = ~clk;

   pcci_host_model pcci_host_model_inst (.clk(clk), .rx_data(rx_data),
      .rx_valid(rx_valid), .rx_ready(rx_ready));
   pcci_top pcci_top_inst (.clk(clk), .rst(rst), .rx_data(rx_data), .rx_valid(rx_valid),
      .rx_ready(rx_ready), .interface_init_input(init_in), .sel_button(sel_btn),
      .page_start_button(pst_btn), .rotary_len(rot), .del_print_sw(del_sw),
      .paper_out(pout), .item_data(item_data), .item_valid(item_valid),
      .item_ready(item_ready), .cfg(cfg), .descender_en(descender_en),
      .paper_end_n(paper_end_n));

   always @(posedge clk)
      if (item_valid === 1'b1 && item_ready === 1'b1)
         items.push_back(item_data);

   // -----------------------------
   // helpers
   // -----------------------------
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wt(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic sb(input logic [7:0] b);
      logic ok;
      pcci_host_model_inst.send(b, ok);
      check("taken", ok, 1);
   endtask

   task automatic esc(input logic [7:0] a);
      sb(`PCCI_ESC);
      sb(a);
      wt(6);
   endtask

   task automatic esc3(input logic [7:0] a, input logic [7:0] d1, input logic [7:0] d2);
      sb(`PCCI_ESC);
      sb(a);
      sb(d1);
      sb(d2);
      wt(8);
   endtask

   task automatic do_reset();
      @(negedge clk);
      rst = 1'b1;
      wt(4);
      rst = 1'b0;
      wt(6);
      items.delete();
   endtask

   task automatic stop_test();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // -----------------------------
   // scenarios
   // -----------------------------
   task automatic t_reset();
      check("pitch", cfg.pitch_16, 0);
      check("lpi", cfg.lpi_8, 0);
      check("short", cfg.short_line, 0);
      check("sel", cfg.selected, 1);
      check("plen", cfg.page_len, rot);
      check("pend", paper_end_n, 1);
   endtask

   task automatic t_pitch();
      sb("A");
      sb(`PCCI_GS);
      wt(6);
      check("pitch mid", cfg.pitch_16, 0);
      sb(`PCCI_RS);
      sb(`PCCI_GS);
      sb(`PCCI_LF);
      wt(6);
      check("pitch eol", cfg.pitch_16, 1);
      sb(`PCCI_US);
      sb("B");
      wt(6);
      check("wide", {items[$].ch, items[$].wide}, {8'h42, 1'b1});
      sb(`PCCI_RS);
      sb("C");
      sb(`PCCI_LF);
      wt(6);
      check("narrow", {items[$ - 1].ch, items[$ - 1].wide}, {8'h43, 1'b0});
      check("pitch back", cfg.pitch_16, 0);
   endtask

   task automatic t_wide();
      sb(`PCCI_US);
      repeat (39) sb("W");
      wt(6);
      check("wide fit", {items[$].ch, items[$].wide}, {8'h57, 1'b1});
      sb("X");
      wt(6);
      check("last narrow", {items[$].ch, items[$].wide}, {8'h58, 1'b0});
      sb(`PCCI_RS);
      sb(`PCCI_LF);
      wt(6);
   endtask

   task automatic t_lines();
      esc(`PCCI_ESC_8);
      sb(`PCCI_LF);
      wt(6);
      check("lpi8", {cfg.lpi_8, descender_en}, 2'b10);
      esc(`PCCI_ESC_6);
      sb(`PCCI_LF);
      wt(6);
      check("lpi6", {cfg.lpi_8, descender_en}, 2'b01);
      esc(`PCCI_ESC_B);
      sb(`PCCI_LF);
      wt(6);
      check("short", cfg.short_line, 1);
      esc(`PCCI_ESC_A);
      sb(`PCCI_LF);
      wt(6);
      check("long", cfg.short_line, 0);
   endtask

   task automatic t_page();
      esc3(`PCCI_ESC_F, "1", "0");
      esc(`PCCI_ESC_5);
      sb(`PCCI_LF);
      sb(`PCCI_LF);
      wt(6);
      check("plen 10", cfg.page_len, 10);
      check("line 2", cfg.page_line, 2);
      sb(`PCCI_FF);
      wt(8);
      check("ff feed", items[$].feed, 8);
      check("ff line", cfg.page_line, 0);
      sb(`PCCI_LF);
      wt(4);
      pst_btn = 1'b1;
      wt(1);
      pst_btn = 1'b0;
      wt(4);
      check("button", cfg.page_line, 0);
      esc3(`PCCI_ESC_F, "0", "0");
      esc(`PCCI_ESC_5);
      check("rotary", cfg.page_len, rot);
      esc3(`PCCI_VT, "1", "2");
      check("skip", items[$].feed, 12);
   endtask

   task automatic t_tab();
      do_reset();
      // small format, channel 1 on line 3
      sb(`PCCI_DC4);
      repeat (3) sb(`PCCI_SP);
      sb("1");
      sb(`PCCI_QMARK);
      wt(6);
      items.delete();
      sb(`PCCI_VT);
      sb("1");
      wt(8);
      check("tab n", items.size(), 1);
      check("tab feed", items[$].feed, 3);
      sb(`PCCI_VT);
      sb(":");
      wt(8);
      check("unset ch", items.size(), 1);
   endtask

   task automatic t_sel_del();
      sb("Q");
      sb(`PCCI_DC3);
      wt(6);
      check("desel wait", cfg.selected, 1);
      sb(`PCCI_LF);
      wt(6);
      check("desel", cfg.selected, 0);
      items.delete();
      sb("A");
      wt(8);
      check("ignored", items.size(), 0);
      sb(`PCCI_DC1);
      wt(6);
      check("resel", cfg.selected, 1);
      sb(`PCCI_DEL);
      wt(8);
      check("del drop", items.size(), 0);
      del_sw = 1'b1;
      sb(`PCCI_DEL);
      wt(8);
      check("del print", items[$].ch, 8'h7f);
      sb(`PCCI_SO);
      sb(`PCCI_US);
      sb("Z");
      wt(8);
      check("so wide", {items[$].ch, items[$].wide, items[$].shift_out}, {8'h5a, 2'b11});
      sb(`PCCI_CAN);
      wt(8);
      check("can", items[$].discard, 1);
      sb("Y");
      wt(8);
      check("can state", {items[$].wide, items[$].shift_out}, 2'b00);
   endtask

   task automatic t_buffer();
      item_ready = 1'b0;
      items.delete();
      sb("A");
      sb("B");
      fork
         sb("C");
      join_none
      wt(12);
      check("full", {rx_ready, item_valid, item_data.ch}, {2'b01, 8'h41});
      item_ready = 1'b1;
      wt(16);
      check("drain", {items[0].ch, items[1].ch, items[2].ch}, 24'h414243);
   endtask

   task automatic t_paper();
      pout = 1'b1;
      wt(1);
      pout = 1'b0;
      repeat (3) sb(`PCCI_LF);
      wt(6);
      check("pe early", paper_end_n, 1);
      sb(`PCCI_LF);
      wt(6);
      check("pe", {paper_end_n, cfg.paper_end, rx_ready}, 3'b010);
      pout = 1'b1;
      init_in = 1'b1;
      wt(1);
      init_in = 1'b0;
      wt(4);
      check("init", {cfg.selected, cfg.pitch_16, cfg.lpi_8}, 0);
   endtask

   // -----------------------------
   // main sequence
   // -----------------------------
   initial
   begin
      wt(4);
      rst = 1'b0;
      wt(6);
      t_reset();
      t_pitch();
      t_wide();
      t_lines();
      t_page();
      t_tab();
      t_sel_del();
      t_buffer();
      t_paper();
      stop_test();
   end

   initial
   begin
      #80000;
      fail_count++;
      stop_test();
   end
endmodule
`default_nettype wire
